// >>> hw/rpd_top.sv
// Read and pre-fetch command block decoder with completion selection.
module rpd_top
    import rpd_pkg::*;
(
    input  wire logic         clk,          // 100 MHz clock.
    input  wire logic         rst,          // Asynchronous reset, active high.
    input  wire logic         cmd_valid,    // Command block offered.
    output logic              cmd_ready,    // Decoder idle and accepting.
    input  wire logic [127:0] cmd_cdb,      // Command bytes, byte 0 on top.
    input  wire logic         pi_formatted, // Medium carries protection info.
    input  wire logic [1:0]   cfg_retention,// Configured retention priority.
    input  wire logic         cfg_readahead,// Read-ahead enabled.
    output logic              media_req,    // One-cycle media operation start.
    output logic      [63:0]  media_lba,    // Operation start address.
    output logic      [31:0]  media_count,  // Blocks; zero means fill segment.
    output logic              media_to_host,// Data goes to initiator.
    output logic              media_force,  // Read medium, not cache.
    output logic              media_pi_send,// Protection info sent with data.
    output logic      [1:0]   media_retention, // Cache retention priority.
    output logic              media_seek_only, // Seek with no transfer.
    output logic              media_readahead, // Start read-ahead after seek.
    input  wire logic         media_done,   // Media operation finished pulse.
    input  wire logic         guard_bad,    // Guard check mismatch.
    input  wire logic         ref_bad,      // Reference tag mismatch.
    output logic              sts_valid,    // Completion pulse.
    output logic      [7:0]   sts_status,   // Status byte.
    output logic      [3:0]   sts_key,      // Sense key.
    output logic      [15:0]  sts_asc       // Additional sense code and qualifier.
);
    rpd_state_e state;
    logic [127:0] cdb;
    logic [63:0]  f_lba;
    logic [31:0]  f_count;
    logic [7:0]   f_flags;
    logic [7:0]   op;
    logic [2:0]   prd;
    logic         is_pf;
    logic         is_rd;
    logic         pi_send;
    logic         pi_fail;
    logic [15:0]  pi_asc;
    logic         bad_op;
    logic         bad_field;
    logic         zero_len;
    logic         pi_seen;

    rpd_field u_field (
        .cdb   (cdb),
        .lba   (f_lba),
        .count (f_count),
        .flags (f_flags)
    );

    rpd_pi_check u_pi (
        .mode      (prd),
        .guard_bad (guard_bad),
        .ref_bad   (ref_bad),
        .send_pi   (pi_send),
        .fail      (pi_fail),
        .fail_asc  (pi_asc)
    );

    // Command decode on the latched block.
    always_comb begin
        op = cdb[127:120];
        is_pf = (op == OP_PREFETCH10) || (op == OP_PREFETCH16);
        is_rd = (op == OP_READ6) || (op == OP_READ10);
        prd = (op == OP_READ10) ? f_flags[PRD_MSB:PRD_LSB] : PRD_NONE;
        bad_op = !(is_pf || is_rd);
        // The non-volatile force bit is never examined.
        bad_field = (is_pf && f_flags[IMMED_BIT])
                 || (!pi_formatted && prd != PRD_NONE)
                 || (prd > PRD_GUARD);
        zero_len = (op == OP_READ10) && (f_count == 32'h0);
    end

    assign cmd_ready = (state == RPD_IDLE);

    // Sequencing: accept, validate, run the media operation, complete.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= RPD_IDLE;
        end else begin
            case (state)
                RPD_IDLE: begin
                    if (cmd_valid) begin
                        state <= RPD_CHECK;
                    end
                end
                RPD_CHECK: begin
                    if (bad_op || bad_field || zero_len) begin
                        state <= RPD_DONE;
                    end else begin
                        state <= RPD_BUSY;
                    end
                end
                RPD_BUSY: begin
                    if (media_done) begin
                        state <= RPD_DONE;
                    end
                end
                default: begin
                    state <= RPD_IDLE;
                end
            endcase
        end
    end

    // Command block capture.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cdb <= 128'h0;
        end else if (state == RPD_IDLE && cmd_valid) begin
            cdb <= cmd_cdb;
        end
    end

    // Media request; a zero-length read still seeks, so it gets a request too.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            media_req <= 1'b0;
            media_lba <= 64'h0;
            media_count <= 32'h0;
            media_to_host <= 1'b0;
            media_force <= 1'b0;
            media_pi_send <= 1'b0;
            media_retention <= 2'b00;
            media_seek_only <= 1'b0;
            media_readahead <= 1'b0;
        end else begin
            media_req <= (state == RPD_CHECK) && !bad_op && !bad_field;
            if (state == RPD_CHECK) begin
                media_lba <= f_lba;
                media_count <= f_count;
                media_to_host <= is_rd && !zero_len;
                media_force <= (op == OP_READ10) && f_flags[FORCE_BIT];
                media_pi_send <= pi_send;
                media_retention <= ((op == OP_READ10) && f_flags[LOWRET_BIT])
                                   ? 2'b00 : cfg_retention;
                media_seek_only <= zero_len;
                media_readahead <= zero_len && cfg_readahead;
            end
        end
    end

    // Protection failures are collected while the transfer runs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pi_seen <= 1'b0;
            sts_asc <= ASC_NONE;
        end else if (state == RPD_CHECK) begin
            pi_seen <= 1'b0;
            sts_asc <= bad_op ? ASC_BAD_OP : (bad_field ? ASC_BAD_CDB : ASC_NONE);
        end else if (state == RPD_BUSY && pi_fail && !pi_seen) begin
            pi_seen <= 1'b1;
            sts_asc <= pi_asc;
        end
    end

    // Completion is one pulse in the cycle after DONE is entered.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sts_valid <= 1'b0;
            sts_status <= ST_GOOD;
            sts_key <= SK_NONE;
        end else begin
            sts_valid <= (state == RPD_DONE);
            if (state == RPD_DONE) begin
                if (bad_op || bad_field) begin
                    sts_status <= ST_CHECK;
                    sts_key <= SK_ILLEGAL;
                end else if (pi_seen) begin
                    sts_status <= ST_CHECK;
                    sts_key <= SK_ABORTED;
                end else begin
                    sts_status <= ST_GOOD;
                    sts_key <= SK_NONE;
                end
            end
        end
    end

    // Assertions.
    a_early_status: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && is_pf && f_flags[IMMED_BIT]) |-> ##2
        (sts_valid && sts_key == SK_ILLEGAL && sts_asc == ASC_BAD_CDB))
        else $error("Early status pre-fetch not rejected.");
    a_pf_no_data: assert property (@(posedge clk) disable iff (rst)
        (media_req && !$past(is_rd)) |-> !media_to_host)
        else $error("Pre-fetch sent data.");
    a_hold_status: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_BUSY && !media_done) |=> !sts_valid)
        else $error("Status before fill finished.");
    a_zero_good: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && zero_len && !bad_field) |-> ##2
        (sts_valid && sts_status == ST_GOOD))
        else $error("Zero-length read not completed at once.");
    a_reserved_mode: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && prd > PRD_GUARD) |=> !media_req ##1 sts_status == ST_CHECK)
        else $error("Reserved protection mode accepted.");
    a_unformatted: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && !pi_formatted && prd != PRD_NONE) |=> !media_req)
        else $error("Protection mode on unformatted medium accepted.");
    a_read6_count: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && op == OP_READ6 && cdb[95:88] == 8'h00)
        |=> media_count == READ6_ZERO_COUNT)
        else $error("Six-byte zero count not 256.");
    // Mismatch flags may drop with the done pulse, so a failure latched earlier counts too.
    a_pi_abort: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_BUSY && media_done && (pi_seen || pi_fail)) |-> ##2
        (sts_valid && sts_status == ST_CHECK && sts_key == SK_ABORTED))
        else $error("Protection failure not aborted.");
    a_low_retain: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && op == OP_READ10 && f_flags[LOWRET_BIT])
        |=> media_retention == 2'b00)
        else $error("Low retention not applied.");
    // Command-specific media set-up, checked one cycle after validation.
    a_pf_start: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && is_pf && !bad_field) |=> (media_req && !media_to_host))
        else $error("Pre-fetch not started as cache fill.");
    a_pf_zero: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && is_pf && f_count == 32'h0) |=> media_count == 32'h0)
        else $error("Zero pre-fetch count altered.");
    a_read6_lba: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && op == OP_READ6) |=> media_lba[63:21] == 43'h0)
        else $error("Six-byte read address too wide.");
    a_read6_no_pi: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && op == OP_READ6) |=> !media_pi_send)
        else $error("Six-byte read sends protection.");
    a_read10_send: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && op == OP_READ10 && !bad_field && f_count != 32'h0)
        |=> (media_req && media_to_host))
        else $error("Ten-byte read not sent to initiator.");
    a_seek_only: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && zero_len && !bad_field)
        |=> (media_req && media_seek_only && media_readahead == $past(cfg_readahead)))
        else $error("Zero-length read did not seek.");
    a_force_media: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && op == OP_READ10 && f_flags[FORCE_BIT]) |=> media_force)
        else $error("Force bit not applied.");
    a_no_pi_mode: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && prd == PRD_NONE) |=> !media_pi_send)
        else $error("Protection sent in mode zero.");
    a_pi_send: assert property (@(posedge clk) disable iff (rst)
        (state == RPD_CHECK && prd != PRD_NONE && prd <= PRD_GUARD) |=> media_pi_send)
        else $error("Protection not sent with data.");
    c_read10: cover property (@(posedge clk) media_req && media_to_host && media_count > 32'h0);
    c_prefetch: cover property (@(posedge clk) media_req && !media_to_host && !media_seek_only);
    c_abort: cover property (@(posedge clk) sts_valid && sts_key == SK_ABORTED);
    c_illegal: cover property (@(posedge clk) sts_valid && sts_key == SK_ILLEGAL);
    c_seek: cover property (@(posedge clk) media_req && media_seek_only && media_readahead);
endmodule

// >>> pkg/rpd_pkg.sv
// Package with opcodes, field positions, status codes and states of the command decoder.
package rpd_pkg;
    // Operation codes.
    localparam logic [7:0] OP_PREFETCH10 = 8'h34;
    localparam logic [7:0] OP_PREFETCH16 = 8'h90;
    localparam logic [7:0] OP_READ6      = 8'h08;
    localparam logic [7:0] OP_READ10     = 8'h28;
    // Byte one field positions.
    localparam int PRD_MSB      = 7;
    localparam int PRD_LSB      = 5;
    localparam int LOWRET_BIT   = 4;
    localparam int FORCE_BIT    = 3;
    localparam int NVFORCE_BIT  = 1;
    localparam int IMMED_BIT    = 1;
    // Protection read modes.
    localparam logic [2:0] PRD_NONE     = 3'h0;
    localparam logic [2:0] PRD_ALL      = 3'h1;
    localparam logic [2:0] PRD_NOGUARD  = 3'h2;
    localparam logic [2:0] PRD_NOCHECK  = 3'h3;
    localparam logic [2:0] PRD_GUARD    = 3'h4;
    // Six-byte read block count when the count byte is zero.
    localparam logic [31:0] READ6_ZERO_COUNT = 32'h0000_0100;
    // Status bytes, sense keys and additional sense codes.
    localparam logic [7:0] ST_GOOD       = 8'h00;
    localparam logic [7:0] ST_CHECK      = 8'h02;
    localparam logic [3:0] SK_NONE       = 4'h0;
    localparam logic [3:0] SK_ILLEGAL    = 4'h5;
    localparam logic [3:0] SK_ABORTED    = 4'hB;
    localparam logic [15:0] ASC_NONE     = 16'h0000;
    localparam logic [15:0] ASC_BAD_CDB  = 16'h2400;
    localparam logic [15:0] ASC_BAD_OP   = 16'h2000;
    localparam logic [15:0] ASC_GUARD    = 16'h1001;
    localparam logic [15:0] ASC_APPTAG   = 16'h1002;
    localparam logic [15:0] ASC_REFTAG   = 16'h1003;
    // Decoder states.
    typedef enum logic [1:0] {
        RPD_IDLE = 2'b00,
        RPD_CHECK = 2'b01,
        RPD_BUSY = 2'b10,
        RPD_DONE = 2'b11
    } rpd_state_e;
endpackage

// >>> hw/rpd_field.sv
// Field extraction of one command block, most significant byte first.
module rpd_field
    import rpd_pkg::*;
(
    input  wire logic [127:0] cdb,          // Command bytes, byte 0 in bits 127:120.
    output logic      [63:0]  lba,          // Logical block address.
    output logic      [31:0]  count,        // Block count after zero handling.
    output logic      [7:0]   flags         // Byte one of the block.
);
    // Byte select with byte zero at the top.
    function automatic logic [7:0] byte_at(input logic [127:0] c, input int i);
        byte_at = c[127 - 8*i -: 8];
    endfunction

    // Fields assembled from ascending byte order.
    always_comb begin
        flags = byte_at(cdb, 1);
        lba = 64'h0;
        count = 32'h0;
        case (byte_at(cdb, 0))
            OP_READ6: begin
                lba = {43'h0, cdb[116:112], byte_at(cdb, 2), byte_at(cdb, 3)};
                count = (byte_at(cdb, 4) == 8'h00) ? READ6_ZERO_COUNT
                                                   : {24'h0, byte_at(cdb, 4)};
            end
            OP_READ10, OP_PREFETCH10: begin
                lba = {32'h0, cdb[111:80]};
                count = {16'h0, cdb[71:56]};
            end
            OP_PREFETCH16: begin
                lba = cdb[111:48];
                count = cdb[47:16];
            end
            default: begin
                lba = 64'h0;
            end
        endcase
    end
endmodule

// >>> hw/rpd_pi_check.sv
// Protection information check enables and failure sense code.
module rpd_pi_check
    import rpd_pkg::*;
(
    input  wire logic [2:0]  mode,          // Protection read mode.
    input  wire logic        guard_bad,     // Guard mismatch seen.
    input  wire logic        ref_bad,       // Reference tag mismatch seen.
    output logic             send_pi,       // Protection info goes to initiator.
    output logic             fail,          // An enabled check failed.
    output logic      [15:0] fail_asc       // Sense code naming the failed field.
);
    logic chk_guard;
    logic chk_ref;

    // Application tag is only checked by the 32-byte read, so never here.
    always_comb begin
        send_pi = (mode != PRD_NONE);
        chk_guard = (mode == PRD_ALL) || (mode == PRD_GUARD);
        chk_ref = (mode == PRD_ALL) || (mode == PRD_NOGUARD);
        fail = (chk_guard && guard_bad) || (chk_ref && ref_bad);
        fail_asc = (chk_guard && guard_bad) ? ASC_GUARD : ASC_REFTAG;
    end
endmodule

// >>> dv/rpd_media_model.sv
// Media engine model that answers decoder media requests, except seek-only ones, with done pulses and check flags.
module rpd_media_model
    import rpd_pkg::*;
(
    input  wire logic       clk,             // Clock.
    input  wire logic       rst,             // Asynchronous reset, active high.
    input  wire logic       media_req,       // Operation start pulse.
    input  wire logic       media_seek_only, // Seek with no transfer.
    input  wire logic [7:0] lat,             // Cycles from start to done, one at least.
    input  wire logic       inj_guard,       // Report a guard mismatch.
    input  wire logic       inj_ref,         // Report a reference tag mismatch.
    output logic            media_done,      // Finished pulse.
    output logic            guard_bad,       // Guard mismatch level.
    output logic            ref_bad          // Reference tag mismatch level.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] left;
    logic       busy;

    // A seek-only start gets no answer, since the decoder completes it on its own.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            left <= 8'h00;
            media_done <= 1'b0;
        end else begin
            media_done <= 1'b0;
            if (media_req && !media_seek_only) begin
                busy <= 1'b1;
                left <= lat;
            end else if (busy) begin
                if (left <= 8'h01) begin
                    media_done <= 1'b1;
                    busy <= 1'b0;
                end else begin
                    left <= left - 8'h01;
                end
            end
        end
    end

    // Mismatch flags only stand while an operation runs, as a real engine would report them.
    assign guard_bad = busy & inj_guard;
    assign ref_bad   = busy & inj_ref;
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the read and pre-fetch command decoder.
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module testbench
    import rpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, cmd_valid, cmd_ready, pi_formatted, cfg_readahead, media_req, media_to_host;
    logic media_force, media_pi_send, media_seek_only, media_readahead, media_done;
    logic guard_bad, ref_bad, sts_valid, inj_guard, inj_ref, got_req, got_sts, bad, abt;
    logic [127:0] cmd_cdb;
    logic [63:0]  media_lba;
    logic [31:0]  media_count;
    logic [15:0]  sts_asc;
    logic [7:0]   sts_status, lat;
    logic [3:0]   sts_key;
    logic [1:0]   cfg_retention, media_retention;
    int cyc, take_cyc, done_cyc, sts_cyc, err_total, n_checks;

    rpd_top u_rpd_top (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_cdb(cmd_cdb), .pi_formatted(pi_formatted), .cfg_retention(cfg_retention),
        .cfg_readahead(cfg_readahead), .media_req(media_req), .media_lba(media_lba),
        .media_count(media_count), .media_to_host(media_to_host), .media_force(media_force),
        .media_pi_send(media_pi_send), .media_retention(media_retention),
        .media_seek_only(media_seek_only), .media_readahead(media_readahead),
        .media_done(media_done), .guard_bad(guard_bad), .ref_bad(ref_bad),
        .sts_valid(sts_valid), .sts_status(sts_status), .sts_key(sts_key), .sts_asc(sts_asc));
    rpd_media_model u_rpd_media_model (.clk(clk), .rst(rst), .media_req(media_req),
        .media_seek_only(media_seek_only), .lat(lat), .inj_guard(inj_guard),
        .inj_ref(inj_ref), .media_done(media_done), .guard_bad(guard_bad), .ref_bad(ref_bad));

    // Free-running clock of 10 ns.
    always #5 clk = ~clk;

    // Monitor flags each start and notes the cycle of each done and completion seen at the edge.
    always @(posedge clk) begin
        cyc++;
        if (media_req === 1'b1) got_req = 1'b1;
        if (media_done === 1'b1) done_cyc = cyc;
        if (sts_valid === 1'b1) begin
            got_sts = 1'b1;
            sts_cyc = cyc;
        end
    end

    function automatic logic [127:0] mk10(input logic [7:0] op, b1, input logic [31:0] a,
                                          input logic [15:0] n);
        return {op, b1, a, 8'h00, n, 8'h00, 48'h0};
    endfunction

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One command: wait for idle, offer for one taken edge, then wait for completion.
    task automatic run(input logic [127:0] c, input logic [7:0] l, input logic ig, ir);
        int n;
        lat = l;
        inj_guard = ig;
        inj_ref = ir;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        got_req = 1'b0;
        got_sts = 1'b0;
        done_cyc = 0;
        cmd_cdb = c;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        take_cyc = cyc;
        cmd_valid = 1'b0;
        n = 0;
        while (!got_sts && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("completion", 1'b1, got_sts)
    endtask

    task automatic sts(input logic [7:0] s, input logic [3:0] k, input logic [15:0] a);
        `CHK("status", s, sts_status)
        `CHK("sense key", k, sts_key)
        if (s !== ST_GOOD) `CHK("sense code", a, sts_asc)
    endtask

    // Watchdog reckoned at dozens of times the expected run length.
    initial begin
        #300000;
        err_total++;
        summarize();
    end

    initial begin
        {clk, cmd_valid, pi_formatted, cfg_readahead, inj_guard, inj_ref} = '0;
        cmd_cdb = '0;
        cfg_retention = 2'h2;
        lat = 8'h01;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        // Ten-byte read, low retention set as a caller would for cold data.
        run(mk10(OP_READ10, 8'h1A, 32'h1122_3344, 16'h0102), 8'h01, 0, 0);
        `CHK("lba", 64'h1122_3344, media_lba)
        `CHK("count", 32'h0102, media_count)
        `CHK("to host", 1'b1, media_to_host)
        `CHK("media start", 1'b1, got_req)
        `CHK("seek only", 1'b0, media_seek_only)
        `CHK("force", 1'b1, media_force)
        `CHK("retention", 2'h0, media_retention)
        sts(ST_GOOD, SK_NONE, ASC_NONE);
        run(mk10(OP_READ10, 8'h00, 32'h0000_0007, 16'h0001), 8'h03, 0, 0);
        `CHK("retention", 2'h2, media_retention)
        `CHK("force", 1'b0, media_force)
        sts(ST_GOOD, SK_NONE, ASC_NONE);
        // Six-byte read on a protected medium, zero and plain counts.
        pi_formatted = 1'b1;
        run({OP_READ6, 8'h1A, 8'hBC, 8'hDE, 8'h00, 88'h0}, 8'h02, 1, 1);
        `CHK("lba", 64'h1A_BCDE, media_lba)
        `CHK("count", 32'h100, media_count)
        `CHK("pi send", 1'b0, media_pi_send)
        sts(ST_GOOD, SK_NONE, ASC_NONE);
        run({OP_READ6, 8'h00, 8'h00, 8'h05, 8'h05, 88'h0}, 8'h02, 0, 0);
        `CHK("count", 32'h5, media_count)
        // Pre-fetch holds status until the fill ends, both prompt and slow.
        for (int i = 0; i < 2; i++) begin
            run(mk10(OP_PREFETCH10, 8'h00, 32'h0A0B_0C0D, 16'h0007), i ? 8'h14 : 8'h01, 0, 0);
            `CHK("to host", 1'b0, media_to_host)
            `CHK("count", 32'h7, media_count)
            `CHK("status delay", 2, sts_cyc - done_cyc)
        end
        run({OP_PREFETCH16, 8'h00, 64'h0102_0304_0506_0708, 32'h0, 16'h0}, 8'h05, 0, 0);
        `CHK("lba", 64'h0102_0304_0506_0708, media_lba)
        `CHK("count", 32'h0, media_count)
        sts(ST_GOOD, SK_NONE, ASC_NONE);
        run(mk10(OP_PREFETCH10, 8'h02, 32'h10, 16'h1), 8'h05, 0, 0);
        `CHK("media start", 1'b0, got_req)
        sts(ST_CHECK, SK_ILLEGAL, ASC_BAD_CDB);
        // An opcode outside the read and pre-fetch family is refused without a media start.
        run({8'hA8, 120'h0}, 8'h05, 0, 0);
        `CHK("media start", 1'b0, got_req)
        sts(ST_CHECK, SK_ILLEGAL, ASC_BAD_OP);
        // Zero-length ten-byte read, with and without read-ahead.
        for (int i = 0; i < 2; i++) begin
            cfg_readahead = i[0];
            run(mk10(OP_READ10, 8'h00, 32'h40, 16'h0), 8'h05, 0, 0);
            `CHK("seek only", 1'b1, media_seek_only)
            `CHK("readahead", i[0], media_readahead)
            `CHK("prompt", 3, sts_cyc - take_cyc)
            sts(ST_GOOD, SK_NONE, ASC_NONE);
        end
        // Every protection mode on both media formats, with each kind of check failure.
        for (int f = 0; f < 2; f++) begin
            pi_formatted = f[0];
            for (int m = 0; m < 8; m++) begin
                for (int e = 0; e < 3; e++) begin
                    run(mk10(OP_READ10, {m[2:0], 5'h00}, 32'h99, 16'h2), 8'h04, e == 1, e == 2);
                    bad = (m > 4) || (f == 0 && m != 0);
                    abt = (e == 1 && (m == 1 || m == 4)) || (e == 2 && (m == 1 || m == 2));
                    if (bad) begin
                        `CHK("media start", 1'b0, got_req)
                        sts(ST_CHECK, SK_ILLEGAL, ASC_BAD_CDB);
                    end else if (abt) begin
                        sts(ST_CHECK, SK_ABORTED, e == 1 ? ASC_GUARD : ASC_REFTAG);
                    end else begin
                        `CHK("pi send", m != 0, media_pi_send)
                        sts(ST_GOOD, SK_NONE, ASC_NONE);
                    end
                end
            end
        end
        summarize();
    end
endmodule
